//--- rtl/ipr_pkg.sv
// shared constants for the interrupt priority and reset block
package ipr_pkg;
	localparam int SRC_TOTAL = 18;
	localparam int MASKABLE_COUNT = 15;
	localparam int PERIPH_COUNT = 14;
	localparam int ID_W = 5;
	localparam int SEL_W = 4;
	// slot of the external request pin among the maskable sources
	localparam logic [3:0] EXT_IRQ_SLOT = 4'h5;
	localparam logic [3:0] PROMOTED_RESET = 4'h5;
	localparam logic [3:0] NO_PROMOTION = 4'hF;
	localparam logic EDGE_MODE_RESET = 1'h0;
	localparam logic CCR_I_RESET = 1'h1;
	localparam logic CCR_X_RESET = 1'h1;
	// identities of the three sources that the global mask cannot block
	localparam logic [4:0] ID_SWI = 5'h0F;
	localparam logic [4:0] ID_ILLEGAL_OP = 5'h10;
	localparam logic [4:0] ID_XIRQ = 5'h11;
	localparam int CLK_PERIOD_NS = 20;
	localparam int RESET_DRIVE_NS = 4000;
	localparam int RESET_DRIVE_CYCLES_INT = (RESET_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] RESET_DRIVE_CYCLES = RESET_DRIVE_CYCLES_INT[7:0];
endpackage

//--- rtl/ipr_flag_if.sv
// carrier between the controller and its sticky status flags
`timescale 1ns/1ps
`default_nettype none
interface ipr_flag_if;
	import ipr_pkg::*;
	logic [MASKABLE_COUNT-1:0] setVec;
	logic [MASKABLE_COUNT-1:0] clrVec;
	logic [MASKABLE_COUNT-1:0] flags;
	modport ctrl (output setVec, output clrVec, input flags);
	modport bank (input setVec, input clrVec, output flags);
endinterface
`default_nettype wire

//--- rtl/ipr_flag_bank.sv
// sticky interrupt status flags, set by events and cleared by software
`timescale 1ns/1ps
`default_nettype none
module ipr_flag_bank
	import ipr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	ipr_flag_if.bank fl
);
	logic [MASKABLE_COUNT-1:0] flags_reg;
	logic [MASKABLE_COUNT-1:0] flags_next;

	// set wins over clear so an event in the clearing cycle is kept
	assign flags_next = (flags_reg & ~fl.clrVec) | fl.setVec;
	assign fl.flags = flags_reg;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= flags_next;
		end
	end

	AST_SET_WINS: assert property (@(posedge core_clk) disable iff (rst)
		(fl.setVec[0] && fl.clrVec[0]) |=> flags_reg[0])
		else $error("flag lost when set and clear coincide");
endmodule
`default_nettype wire

//--- rtl/ipr_controller.sv
// interrupt collection, prioritisation and reset output for the cpu core
`timescale 1ns/1ps
`default_nettype none
module ipr_controller
	import ipr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [PERIPH_COUNT-1:0] periphEvent,
	input wire logic [PERIPH_COUNT-1:0] periphClear,
	input wire logic extIrqN,
	input wire logic extIrqClear,
	input wire logic xirqN,
	input wire logic swiReq,
	input wire logic illegalOpReq,
	input wire logic ccrWrite,
	input wire logic ccrIIn,
	input wire logic ccrXIn,
	output logic ccrI,
	output logic ccrX,
	input wire logic prioWrite,
	input wire logic [SEL_W-1:0] prioData,
	output logic [SEL_W-1:0] promotedSource,
	input wire logic edgeWrite,
	input wire logic edgeIn,
	output logic irqEdgeMode,
	output logic [MASKABLE_COUNT-1:0] pendingFlags,
	output logic irqValid,
	output logic [ID_W-1:0] irqId,
	output logic irqNonMaskable,
	input wire logic copFail,
	input wire logic clockFail,
	input wire logic resetPinIn,
	output logic resetPinOut,
	output logic resetPinOe,
	output logic internalReset
);
	// ******************************
	// helpers
	// ******************************
	function automatic logic [3:0] firstSet(input logic [MASKABLE_COUNT-1:0] v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int k = MASKABLE_COUNT - 1; k >= 0; k--) begin
			if (v[k]) begin
				idx = 4'(k);
			end
		end
		return idx;
	endfunction

	// ******************************
	// control state
	// ******************************
	logic ccrI_reg;
	logic ccrI_next;
	logic ccrX_reg;
	logic ccrX_next;
	logic [SEL_W-1:0] prio_reg;
	logic [SEL_W-1:0] prio_next;
	logic edge_reg;
	logic edge_next;
	logic extPrev_reg;
	logic [7:0] drive_reg;
	logic [7:0] drive_next;

	// x may be cleared by software but only reset sets it again
	assign ccrI_next = ccrWrite ? ccrIIn : ccrI_reg;
	assign ccrX_next = ccrWrite ? (ccrX_reg & ccrXIn) : ccrX_reg;
	// writes with the mask open are dropped so the ranking cannot shift mid-service
	assign prio_next = (prioWrite && ccrI_reg) ? prioData : prio_reg;
	assign edge_next = edgeWrite ? edgeIn : edge_reg;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ccrI_reg <= CCR_I_RESET;
			ccrX_reg <= CCR_X_RESET;
			prio_reg <= PROMOTED_RESET;
			edge_reg <= EDGE_MODE_RESET;
			extPrev_reg <= 1'h1;
			drive_reg <= 8'h00;
		end else begin
			ccrI_reg <= ccrI_next;
			ccrX_reg <= ccrX_next;
			prio_reg <= prio_next;
			edge_reg <= edge_next;
			extPrev_reg <= extIrqN;
			drive_reg <= drive_next;
		end
	end

	assign ccrI = ccrI_reg;
	assign ccrX = ccrX_reg;
	assign promotedSource = prio_reg;
	assign irqEdgeMode = edge_reg;

	// ******************************
	// status flags
	// ******************************
	ipr_flag_if fl ();
	wire extFall = extPrev_reg & ~extIrqN;
	wire extEdgeSet = edge_reg & extFall;

	assign fl.setVec = {periphEvent[13:5], extEdgeSet, periphEvent[4:0]};
	assign fl.clrVec = {periphClear[13:5], extIrqClear, periphClear[4:0]};

	ipr_flag_bank u_flags (
		.core_clk(core_clk),
		.rst(rst),
		.fl(fl.bank)
	);

	assign pendingFlags = fl.flags;

	// ******************************
	// prioritisation
	// ******************************
	logic [MASKABLE_COUNT-1:0] maskReq;
	always_comb begin
		maskReq = fl.flags;
		// level mode follows the pin itself so wired-or sharers keep it asserted
		maskReq[EXT_IRQ_SLOT] = edge_reg ? fl.flags[EXT_IRQ_SLOT] : ~extIrqN;
	end

	wire [MASKABLE_COUNT-1:0] maskGated = ccrI_reg ? '0 : maskReq;
	wire xirqReq = ~xirqN & ~ccrX_reg;
	wire [MASKABLE_COUNT-1:0] nmVec = {12'h000, xirqReq, illegalOpReq, swiReq};
	wire nmAny = |nmVec;
	wire [3:0] nmIdx = firstSet(nmVec);
	wire promValid = (prio_reg != NO_PROMOTION) && maskGated[prio_reg];
	wire [3:0] mkIdx = promValid ? prio_reg : firstSet(maskGated);

	assign irqNonMaskable = nmAny;
	assign irqValid = nmAny | (|maskGated);
	assign irqId = nmAny ? (ID_SWI + {3'h0, nmIdx[1:0]}) : {1'h0, mkIdx};

	// ******************************
	// reset output
	// ******************************
	wire faultSeen = copFail | clockFail;
	assign drive_next = faultSeen ? RESET_DRIVE_CYCLES : (drive_reg != 8'h00 ? drive_reg - 8'h01 : 8'h00);
	assign resetPinOe = (drive_reg != 8'h00);
	assign resetPinOut = 1'h0;
	// an external low on the pin resets the core just as our own drive does
	assign internalReset = resetPinOe | ~resetPinIn;

	// ******************************
	// checks
	// ******************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence sPinDriven;
		(resetPinOe && !resetPinOut && internalReset)[*8];
	endsequence

	sequence sMaskedWrite;
		prioWrite && !ccrI;
	endsequence

	AST_ID_RANGE: assert property (irqValid |-> (irqId < 5'h12))
		else $error("identity outside source range");
	AST_MASK_BLOCKS: assert property ((ccrI && irqValid) |-> irqNonMaskable)
		else $error("maskable request passed with mask set");
	AST_NM_UNMASKED: assert property ((swiReq && !illegalOpReq) |-> (irqValid && irqId == ID_SWI))
		else $error("non-maskable request blocked");
	AST_PROMOTED_WINS: assert property ((!ccrI && !nmAny && promotedSource == 4'h9 && maskReq[9])
		|-> (irqId == 5'h09))
		else $error("promoted source not ranked first");
	AST_PRIO_IGNORED: assert property (sMaskedWrite |=> $stable(promotedSource))
		else $error("priority select changed with mask clear");
	AST_PRIO_TAKEN: assert property ((prioWrite && ccrI) |=> (promotedSource == $past(prioData)))
		else $error("priority select write lost");
	AST_FLAG_SETS: assert property (periphEvent[0] |=> pendingFlags[0])
		else $error("event did not set flag");
	AST_FLAG_HOLDS: assert property ((pendingFlags[0] && !periphClear[0]) |=> pendingFlags[0])
		else $error("flag dropped without clear");
	AST_RESET_DRIVE: assert property (copFail |=> sPinDriven)
		else $error("reset pin not driven after fault");
	AST_LEVEL_FOLLOWS: assert property ((!irqEdgeMode && !ccrI && !nmAny && !extIrqN) |-> irqValid)
		else $error("level request on external pin not seen");

	// ******************************
	// edge mode, x mask and drive end checks
	// ******************************
	sequence sExtFallEdge;
		irqEdgeMode && extPrev_reg && !extIrqN;
	endsequence

	AST_EDGE_SETS: assert property (sExtFallEdge |=> pendingFlags[EXT_IRQ_SLOT])
		else $error("falling edge did not set external flag");
	AST_EDGE_NO_LEVEL: assert property ((irqEdgeMode && pendingFlags == '0 && !nmAny) |-> !irqValid)
		else $error("edge mode request seen without flag");
	AST_EXT_CLEAR: assert property ((extIrqClear && !extEdgeSet) |=> !pendingFlags[EXT_IRQ_SLOT])
		else $error("external flag not cleared");
	AST_XIRQ_MASKED: assert property ((ccrX && !swiReq && !illegalOpReq) |-> !irqNonMaskable)
		else $error("pin request passed with x mask set");
	AST_XIRQ_ID: assert property ((!xirqN && !ccrX && !swiReq && !illegalOpReq) |-> (irqNonMaskable && irqId == ID_XIRQ))
		else $error("pin request not presented");
	AST_X_NO_SET: assert property (!ccrX |=> !ccrX)
		else $error("x mask set again without reset");
	AST_CLOCK_FAIL_DRIVE: assert property (clockFail |=> resetPinOe)
		else $error("reset pin not driven after clock fault");
	AST_DRIVE_ENDS: assert property ((drive_reg == 8'h01 && !faultSeen) |=> !resetPinOe)
		else $error("reset pin drive did not end");
endmodule
`default_nettype wire

//--- testbench/ipr_cpu_model.sv
// behavioural cpu core that takes the presented interrupt identity
`timescale 1ns/1ps
`default_nettype none
module ipr_cpu_model
	import ipr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic irqValid,
	input wire logic [ID_W-1:0] irqId,
	output logic [ID_W-1:0] takenId
);
	logic [ID_W-1:0] takenId_reg;
	// 1F marks that nothing has been taken since reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			takenId_reg <= 5'h1F;
		end else if (irqValid) begin
			takenId_reg <= irqId;
		end
	end
	assign takenId = takenId_reg;
endmodule
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the interrupt priority and reset block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ipr_pkg::*;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	logic [13:0] pEv = 14'h0;
	logic [13:0] pClr = 14'h0;
	logic extIrqN = 1'h1, swiReq = 1'h0, illOp = 1'h0, ccrWrite = 1'h0, ccrIIn = 1'h1, prioWrite = 1'h0;
	logic copFail = 1'h0, clockFail = 1'h0, xirqN = 1'h1;
	logic extClr = 1'h0, edgeWr = 1'h0, edgeDat = 1'h0, xIn = 1'h1;
	logic [3:0] prioData = 4'h0;
	logic ccrI, ccrX, irqEdgeMode, irqValid, irqNm, rOut, rOe, intRst, rPin;
	logic [3:0] promo;
	logic [14:0] pend;
	logic [4:0] irqId, takenId;
	int n_errors = 0;
	int n_compared = 0;
	always #10 core_clk = ~core_clk;
	// pulled-up reset pin, only ever driven low
	assign rPin = rOe ? rOut : 1'h1;
	ipr_controller ipr_controller_inst (.core_clk(core_clk), .rst(rst), .periphEvent(pEv), .periphClear(pClr),
		.extIrqN(extIrqN), .extIrqClear(extClr), .xirqN(xirqN), .swiReq(swiReq), .illegalOpReq(illOp),
		.ccrWrite(ccrWrite), .ccrIIn(ccrIIn), .ccrXIn(xIn), .ccrI(ccrI), .ccrX(ccrX), .prioWrite(prioWrite),
		.prioData(prioData), .promotedSource(promo), .edgeWrite(edgeWr), .edgeIn(edgeDat), .irqEdgeMode(irqEdgeMode),
		.pendingFlags(pend), .irqValid(irqValid), .irqId(irqId), .irqNonMaskable(irqNm), .copFail(copFail),
		.clockFail(clockFail), .resetPinIn(rPin), .resetPinOut(rOut), .resetPinOe(rOe), .internalReset(intRst));
	ipr_cpu_model ipr_cpu_model_inst (.core_clk(core_clk), .rst(rst), .irqValid(irqValid), .irqId(irqId),
		.takenId(takenId));
	// ****
	// helpers
	// ****
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task pulse(input logic [13:0] ev, input logic [13:0] clr);
		@(posedge core_clk);
		pEv <= ev;
		pClr <= clr;
		@(posedge core_clk);
		pEv <= 14'h0;
		pClr <= 14'h0;
		#1;
	endtask
	task setMask(input logic i);
		@(posedge core_clk);
		ccrWrite <= 1'h1;
		ccrIIn <= i;
		@(posedge core_clk);
		ccrWrite <= 1'h0;
		#1;
	endtask
	task writePrio(input logic [3:0] v);
		@(posedge core_clk);
		prioWrite <= 1'h1;
		prioData <= v;
		@(posedge core_clk);
		prioWrite <= 1'h0;
		#1;
	endtask
	// ****
	// scenarios
	// ****
	task test_reset_values;
		chk("ccrI", 1, ccrI);
		chk("ccrX", 1, ccrX);
		chk("promo", 5, promo);
		chk("edgeMode", 0, irqEdgeMode);
		chk("pend", 0, pend);
		chk("valid", 0, irqValid);
	endtask
	task test_flag_and_mask;
		pulse(14'h1, 14'h0);
		chk("pend0", 1, pend[0]);
		chk("maskedValid", 0, irqValid);
		setMask(1'h0);
		chk("valid", 1, irqValid);
		tick(3);
		chk("sticky", 1, pend[0]);
		pulse(14'h0, 14'h1);
		chk("cleared", 0, pend[0]);
		chk("idle", 0, irqValid);
	endtask
	task test_all_ids;
		for (int k = 0; k < 14; k++) begin
			pulse(14'h1 << k, 14'h0);
			chk("id", (k < 5) ? k : k + 1, irqId);
			pulse(14'h0, 14'h1 << k);
		end
		@(posedge core_clk);
		extIrqN <= 1'h0;
		tick(2);
		chk("extId", 5, irqId);
		@(posedge core_clk);
		extIrqN <= 1'h1;
	endtask
	task test_promotion;
		writePrio(4'h9);
		chk("refused", 5, promo);
		setMask(1'h1);
		writePrio(4'h9);
		chk("promo", 9, promo);
		setMask(1'h0);
		pulse(14'h101, 14'h0);
		chk("promoted", 9, irqId);
		pulse(14'h0, 14'h101);
	endtask
	task test_nonmaskable;
		setMask(1'h1);
		@(posedge core_clk);
		swiReq <= 1'h1;
		illOp <= 1'h1;
		tick(2);
		chk("nm", 1, irqNm);
		chk("swi", ID_SWI, takenId);
		@(posedge core_clk);
		swiReq <= 1'h0;
		tick(2);
		chk("ill", ID_ILLEGAL_OP, irqId);
		@(posedge core_clk);
		illOp <= 1'h0;
	endtask
	task test_edge_and_xirq;
		@(posedge core_clk);
		xirqN <= 1'h0;
		tick(2);
		chk("xMasked", 0, irqNm);
		@(posedge core_clk);
		ccrWrite <= 1'h1;
		ccrIIn <= 1'h0;
		xIn <= 1'h0;
		@(posedge core_clk);
		ccrWrite <= 1'h0;
		xIn <= 1'h1;
		#1;
		chk("ccrXClr", 0, ccrX);
		chk("xirq", ID_XIRQ, irqId);
		chk("xNm", 1, irqNm);
		setMask(1'h0);
		chk("xSticky", 0, ccrX);
		@(posedge core_clk);
		xirqN <= 1'h1;
		edgeWr <= 1'h1;
		edgeDat <= 1'h1;
		@(posedge core_clk);
		edgeWr <= 1'h0;
		#1;
		chk("edgeSet", 1, irqEdgeMode);
		@(posedge core_clk);
		extIrqN <= 1'h0;
		tick(2);
		chk("edgeFlag", 1, pend[5]);
		chk("edgeId", 5, irqId);
		@(posedge core_clk);
		extIrqN <= 1'h1;
		tick(2);
		chk("edgeHeld", 1, pend[5]);
		@(posedge core_clk);
		extClr <= 1'h1;
		@(posedge core_clk);
		extClr <= 1'h0;
		#1;
		chk("edgeClr", 0, pend[5]);
		chk("edgeIdle", 0, irqValid);
	endtask
	task test_reset_out;
		@(posedge core_clk);
		copFail <= 1'h1;
		@(posedge core_clk);
		copFail <= 1'h0;
		#1;
		chk("pin", 0, rPin);
		chk("intRst", 1, intRst);
		tick(199);
		chk("held", 1, rOe);
		tick(1);
		chk("drop", 0, rOe);
		@(posedge core_clk);
		clockFail <= 1'h1;
		@(posedge core_clk);
		clockFail <= 1'h0;
		#1;
		chk("clkFail", 1, rOe);
	endtask
	task tally_and_finish;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// generous against the few hundred cycles the scenarios need
	initial begin
		#(20 * 20000);
		n_errors++;
		tally_and_finish();
	end
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'h0;
		tick(1);
		test_reset_values();
		test_flag_and_mask();
		test_all_ids();
		test_promotion();
		test_nonmaskable();
		test_edge_and_xirq();
		test_reset_out();
		tally_and_finish();
	end
endmodule
`default_nettype wire
